// File: hdl/irq_pkg.sv
/*
 * Constants for the core interrupt enable and flag block: APB offsets,
 * bit positions inside the control and status registers, reset values.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package irq_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PERIPH_EN = 12'h004;
    localparam logic [11:0] OFS_OPT = 12'h008;
    localparam logic [11:0] OFS_PCHG = 12'h00C;
    localparam logic [11:0] OFS_STAT = 12'h010;
    localparam logic [11:0] OFS_MASK = 12'h014;

    // Interrupt control bits
    localparam int MASTER_IRQ_GATE = 7;
    localparam int PERIPH_IRQ_GATE = 6;
    localparam int TIMER_OVF_EN = 5;
    localparam int EXT_PIN_IRQ_EN = 4;
    localparam int PORT_CHANGE_EN = 3;
    localparam int TIMER_OVF_FLAG = 2;
    localparam int EXT_PIN_IRQ_FLAG = 1;
    localparam int PORT_CHANGE_FLAG = 0;

    // Option register bit
    localparam int EXT_EDGE_SELECT = 0;

    // Event status bits
    localparam int EV_W = 4;
    localparam int EV_PORT = 0;
    localparam int EV_EXT = 1;
    localparam int EV_TIMER = 2;
    localparam int EV_VECTOR = 3;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PERIPH_EN_RESET = 8'h00;
    localparam logic [7:0] PCHG_RESET = 8'h00;
    localparam logic [3:0] EV_RESET = 4'h0;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    localparam logic [12:0] VECTOR_RESET = 13'h0000;
endpackage

// File: hdl/core_interrupt_enable_flags.sv
/*
 * Interrupt control register, first peripheral enable register, edge
 * and pin-change detection, request to the core and an APB slave.
 * Assumes all inputs synchronous to pclk; event inputs are pulses.
 */
// Register access over APB and the register offsets were left to the implementer.
// Summary of operation
// - Master gate set passes unmasked requests; clear blocks every request on irq_request, but irq is not gated.
// - Peripheral gate must be set for peripheral-enabled requests to pass.
// - Flags set on their event regardless of enables or master gate.
// - Timer rollover sets timer flag bit 2; enable bit 5 gates it.
// - Valid external pin edge sets flag bit 1; enable bit 4 gates it.
// - Any enabled port pin change sets flag bit 0; enable bit 3.
// - Port change needs the per-pin change enable bit set.
// - Control register fully read/write; resets to zero here.
// - Peripheral enable register: eight read/write bits resetting to zero.
// - Taken interrupt clears master gate and presents vector 0004h.
// - Edge select set means rising edge, clear means falling edge.
// - Reset leaves every interrupt disabled.
module core_interrupt_enable_flags #(
    parameter int PORT_WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irq_pkg::ADDR_W-1:0] paddr,
    input wire logic [irq_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [irq_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_rollover,
    input wire logic ext_pin,
    input wire logic [PORT_WIDTH-1:0] port_pins,
    input wire logic [7:0] periph_flags,
    input wire logic irq_taken,
    input wire logic irq_return,
    output logic irq_request,
    output logic [12:0] vector_addr,
    output logic irq
);

    if (PORT_WIDTH < 1 || PORT_WIDTH > 8) begin : g_check
        $error("PORT_WIDTH must be 1 to 8");
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] periph_en;
        logic edge_sel;
        logic [7:0] pchg;
        logic [irq_pkg::EV_W-1:0] status;
        logic [irq_pkg::EV_W-1:0] mask;
        logic [PORT_WIDTH-1:0] pin_prev;
        logic ext_prev;
        logic primed;
        logic [irq_pkg::DATA_W-1:0] rdata;
        logic [12:0] vector;
    } state_type;

    state_type state_reg;
    state_type state_next;

    function automatic logic addr_hit(input logic [irq_pkg::ADDR_W-1:0] a);
        unique case (a)
            irq_pkg::OFS_CTRL, irq_pkg::OFS_PERIPH_EN, irq_pkg::OFS_OPT,
            irq_pkg::OFS_PCHG, irq_pkg::OFS_STAT, irq_pkg::OFS_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input logic [irq_pkg::ADDR_W-1:0] a,
                                              input state_type s);
        read_word = '0;
        unique case (a)
            irq_pkg::OFS_CTRL: read_word[7:0] = s.ctrl;
            irq_pkg::OFS_PERIPH_EN: read_word[7:0] = s.periph_en;
            irq_pkg::OFS_OPT: read_word[irq_pkg::EXT_EDGE_SELECT] = s.edge_sel;
            irq_pkg::OFS_PCHG: read_word[7:0] = s.pchg;
            irq_pkg::OFS_STAT: read_word[irq_pkg::EV_W-1:0] = s.status;
            irq_pkg::OFS_MASK: read_word[irq_pkg::EV_W-1:0] = s.mask;
            default: read_word = '0;
        endcase
    endfunction

    logic wr_en;
    logic rd_setup;
    logic ctrl_wr;
    logic [7:0] pin_enable;
    logic port_change;
    logic ext_edge;
    logic core_pairs;
    logic periph_pairs;
    logic [irq_pkg::EV_W-1:0] events;

    // Low byte lane carries every register; other lanes are ignored
    assign wr_en = psel && penable && pwrite && pstrb[0] && addr_hit(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign ctrl_wr = wr_en && paddr == irq_pkg::OFS_CTRL;

    // Zero wait states: read data was captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);
    assign prdata = state_reg.rdata;

    always_comb begin
        pin_enable = '0;
        pin_enable[PORT_WIDTH-1:0] = state_reg.pchg[PORT_WIDTH-1:0];
    end

    // Edge detectors wait one cycle after reset so pins at rest do not fire
    assign port_change = state_reg.primed
        && |((port_pins ^ state_reg.pin_prev) & pin_enable[PORT_WIDTH-1:0]);
    assign ext_edge = state_reg.primed && (state_reg.edge_sel
        ? (ext_pin && !state_reg.ext_prev)
        : (!ext_pin && state_reg.ext_prev));

    assign events = {irq_taken, timer_rollover, ext_edge, port_change};

    assign core_pairs =
        (state_reg.ctrl[irq_pkg::TIMER_OVF_EN] && state_reg.ctrl[irq_pkg::TIMER_OVF_FLAG])
        || (state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_EN]
            && state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG])
        || (state_reg.ctrl[irq_pkg::PORT_CHANGE_EN]
            && state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG]);
    assign periph_pairs = state_reg.ctrl[irq_pkg::PERIPH_IRQ_GATE]
        && |(state_reg.periph_en & periph_flags);
    assign irq_request = state_reg.ctrl[irq_pkg::MASTER_IRQ_GATE]
        && (core_pairs || periph_pairs);
    assign irq = |(state_reg.status & state_reg.mask);
    assign vector_addr = state_reg.vector;

    always_comb begin
        state_next = state_reg;
        state_next.primed = 1'b1;
        state_next.pin_prev = port_pins;
        state_next.ext_prev = ext_pin;
        if (rd_setup) begin
            state_next.rdata = read_word(paddr, state_reg);
        end
        if (wr_en) begin
            unique case (paddr)
                irq_pkg::OFS_CTRL: state_next.ctrl = pwdata[7:0];
                irq_pkg::OFS_PERIPH_EN: state_next.periph_en = pwdata[7:0];
                irq_pkg::OFS_OPT: state_next.edge_sel = pwdata[irq_pkg::EXT_EDGE_SELECT];
                irq_pkg::OFS_PCHG: state_next.pchg = pwdata[7:0];
                irq_pkg::OFS_STAT: state_next.status = state_reg.status
                    & ~pwdata[irq_pkg::EV_W-1:0];
                irq_pkg::OFS_MASK: state_next.mask = pwdata[irq_pkg::EV_W-1:0];
                default: state_next.mask = state_reg.mask;
            endcase
        end
        // Hardware sets after software writes, so an event never gets lost
        if (timer_rollover) begin
            state_next.ctrl[irq_pkg::TIMER_OVF_FLAG] = 1'b1;
        end
        if (ext_edge) begin
            state_next.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG] = 1'b1;
        end
        if (port_change) begin
            state_next.ctrl[irq_pkg::PORT_CHANGE_FLAG] = 1'b1;
        end
        if (irq_return) begin
            state_next.ctrl[irq_pkg::MASTER_IRQ_GATE] = 1'b1;
        end
        // Taking the vector wins over a simultaneous return or write
        if (irq_taken) begin
            state_next.ctrl[irq_pkg::MASTER_IRQ_GATE] = 1'b0;
            state_next.vector = irq_pkg::VECTOR_ADDR;
        end
        state_next.status = state_next.status | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.ctrl <= irq_pkg::CTRL_RESET;
            state_reg.periph_en <= irq_pkg::PERIPH_EN_RESET;
            state_reg.edge_sel <= 1'b1;
            state_reg.pchg <= irq_pkg::PCHG_RESET;
            state_reg.status <= irq_pkg::EV_RESET;
            state_reg.mask <= irq_pkg::EV_RESET;
            state_reg.pin_prev <= '0;
            state_reg.ext_prev <= 1'b0;
            state_reg.primed <= 1'b0;
            state_reg.rdata <= '0;
            state_reg.vector <= irq_pkg::VECTOR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic master_gate;
    logic no_hw;
    assign master_gate = state_reg.ctrl[irq_pkg::MASTER_IRQ_GATE];
    assign no_hw = !timer_rollover && !ext_edge && !port_change && !irq_taken && !irq_return;

    property p_master_gate;
        !master_gate |-> !irq_request;
    endproperty
    a_master_gate: assert property (p_master_gate)
        else $error("request with master gate clear");

    property p_periph_gate;
        !state_reg.ctrl[irq_pkg::PERIPH_IRQ_GATE] && !core_pairs |-> !irq_request;
    endproperty
    a_periph_gate: assert property (p_periph_gate)
        else $error("peripheral request passed closed gate");

    property p_flag_any_enable;
        timer_rollover && !master_gate |=> state_reg.ctrl[irq_pkg::TIMER_OVF_FLAG];
    endproperty
    a_flag_any_enable: assert property (p_flag_any_enable)
        else $error("flag not set with gate clear");

    property p_timer_sticky;
        state_reg.ctrl[irq_pkg::TIMER_OVF_FLAG] && !ctrl_wr
            |=> state_reg.ctrl[irq_pkg::TIMER_OVF_FLAG] [*2] or ctrl_wr;
    endproperty
    a_timer_sticky: assert property (p_timer_sticky)
        else $error("timer flag dropped without software");

    property p_ext_rise;
        state_reg.primed && state_reg.edge_sel && $rose(ext_pin)
            |=> state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_rise: assert property (p_ext_rise)
        else $error("rising edge missed");

    property p_ext_fall;
        state_reg.primed && !state_reg.edge_sel && $fell(ext_pin) && !ctrl_wr
            ##1 !ctrl_wr |-> state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_fall: assert property (p_ext_fall)
        else $error("falling edge missed");

    property p_port_change;
        port_change |=> state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG]
            && state_reg.status[irq_pkg::EV_PORT];
    endproperty
    a_port_change: assert property (p_port_change)
        else $error("port change not recorded");

    property p_pin_enable;
        state_reg.primed && !state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG] && !ctrl_wr
            && ((port_pins ^ state_reg.pin_prev) & pin_enable[PORT_WIDTH-1:0]) == '0
            |=> !state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG];
    endproperty
    a_pin_enable: assert property (p_pin_enable)
        else $error("disabled pin set port flag");

    property p_ctrl_rw;
        ctrl_wr && no_hw |=> state_reg.ctrl == $past(pwdata[7:0]);
    endproperty
    a_ctrl_rw: assert property (p_ctrl_rw)
        else $error("control write lost");

    // Read data is the word as it stood at the setup edge
    property p_ctrl_readback;
        rd_setup && paddr == irq_pkg::OFS_CTRL
            |=> prdata[7:0] == $past(state_reg.ctrl);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control readback mismatch");

    property p_periph_en_rw;
        wr_en && paddr == irq_pkg::OFS_PERIPH_EN
            |=> state_reg.periph_en == $past(pwdata[7:0]);
    endproperty
    a_periph_en_rw: assert property (p_periph_en_rw)
        else $error("peripheral enable write lost");

    property p_vector;
        irq_taken |=> !master_gate && vector_addr == irq_pkg::VECTOR_ADDR
            && irq_pkg::EV_VECTOR < irq_pkg::EV_W;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector entry wrong");

    // Opening side of the gates; the closing side is checked above
    property p_core_pair_pass;
        master_gate && ((state_reg.ctrl[irq_pkg::TIMER_OVF_EN]
            && state_reg.ctrl[irq_pkg::TIMER_OVF_FLAG])
            || (state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_EN]
            && state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG])
            || (state_reg.ctrl[irq_pkg::PORT_CHANGE_EN]
            && state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG])) |-> irq_request;
    endproperty
    a_core_pair_pass: assert property (p_core_pair_pass)
        else $error("enabled core flag did not request");

    property p_periph_pass;
        master_gate && state_reg.ctrl[irq_pkg::PERIPH_IRQ_GATE]
            && |(state_reg.periph_en & periph_flags) |-> irq_request;
    endproperty
    a_periph_pass: assert property (p_periph_pass)
        else $error("enabled peripheral did not request");

    property p_ext_any_enable;
        ext_edge && !state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_EN]
            |=> state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_any_enable: assert property (p_ext_any_enable)
        else $error("pin flag waited for its enable");

    property p_ext_sticky;
        state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG] && !ctrl_wr
            |=> state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_sticky: assert property (p_ext_sticky)
        else $error("pin flag dropped without software");

    property p_port_sticky;
        state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG] && !ctrl_wr
            |=> state_reg.ctrl[irq_pkg::PORT_CHANGE_FLAG];
    endproperty
    a_port_sticky: assert property (p_port_sticky)
        else $error("port flag dropped without software");

    // Wrong edge must leave a clear flag clear
    property p_ext_no_fall;
        state_reg.primed && state_reg.edge_sel && $fell(ext_pin)
            && !state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG] && !ctrl_wr
            |=> !state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_no_fall: assert property (p_ext_no_fall)
        else $error("falling edge set flag in rising mode");

    property p_ext_no_rise;
        state_reg.primed && !state_reg.edge_sel && $rose(ext_pin)
            && !state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG] && !ctrl_wr
            |=> !state_reg.ctrl[irq_pkg::EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_no_rise: assert property (p_ext_no_rise)
        else $error("rising edge set flag in falling mode");

    property p_reset_quiet;
        !state_reg.primed |-> !irq_request && !irq;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("interrupt live after reset");

endmodule

// File: tb/core_model.sv
/*
 * Far side of the interrupt block: a core that takes the vector when
 * allowed, and an 8-bit timer counter that emits rollover pulses.
 * Assumes pclk and presetn of the bench; commands come from tb.
 */
module core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_request,
    input wire logic take_en,
    input wire logic ret_cmd,
    input wire logic tmr_load,
    input wire logic tmr_run,
    output logic irq_taken,
    output logic irq_return,
    output logic timer_rollover
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] timer_counter;
    // One pulse per wrap, only while counting
    assign timer_rollover = tmr_run && timer_counter == 8'hFF;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_taken <= 1'h0;
            irq_return <= 1'h0;
        end else begin
            irq_taken <= take_en && irq_request && !irq_taken;
            irq_return <= ret_cmd;
        end
    end
    // Counter survives reset, hence no reset branch
    always_ff @(posedge pclk) begin
        if (tmr_load)
            timer_counter <= 8'hFD;
        else if (tmr_run)
            timer_counter <= timer_counter + 8'h01;
    end
endmodule

// File: tb/tb.sv
/*
 * Self-checking bench: APB master, random and directed interrupt cases.
 * Assumes core_interrupt_enable_flags, irq_pkg and core_model.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ext_pin = 1'h0;
    logic take_en = 1'h0, ret_cmd = 1'h0, tmr_load = 1'h0, tmr_run = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0, strb = 4'hF;
    logic [7:0] port_pins = 8'h00, periph_flags = 8'h00, c, p, f;
    logic [31:0] prdata, rdat;
    logic [12:0] vector_addr;
    logic pready, pslverr, irq_taken, irq_return, irq_request, irq, rollover, rerr;
    int fail_count = 0, checks_done = 0, cyc = 0;

    always #2 pclk = ~pclk;

    core_interrupt_enable_flags #(.PORT_WIDTH(8)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_rollover(rollover), .ext_pin(ext_pin), .port_pins(port_pins),
        .periph_flags(periph_flags), .irq_taken(irq_taken), .irq_return(irq_return),
        .irq_request(irq_request), .vector_addr(vector_addr), .irq(irq));
    core_model core (
        .pclk(pclk), .presetn(presetn), .irq_request(irq_request), .take_en(take_en),
        .ret_cmd(ret_cmd), .tmr_load(tmr_load), .tmr_run(tmr_run),
        .irq_taken(irq_taken), .irq_return(irq_return), .timer_rollover(rollover));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Outputs are read mid-cycle so the last write has landed
    task automatic pin_chk(input logic e, input logic is_irq);
        @(negedge pclk);
        chk({31'h0, is_irq ? irq : irq_request}, {31'h0, e});
        // Back on the rising edge so callers drive where the bus expects it
        @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rdat, exp);
    endtask

    function automatic logic exp_req(input logic [7:0] ct, input logic [7:0] pe,
                                     input logic [7:0] pf);
        return ct[7] && ((ct[5:3] & ct[2:0]) != 3'h0 || (ct[6] && (pe & pf) != 8'h00));
    endfunction

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        rdat = $urandom(43419);
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        rd(irq_pkg::OFS_CTRL, 32'h0);
        rd(irq_pkg::OFS_PERIPH_EN, 32'h0);
        rd(irq_pkg::OFS_OPT, 32'h1);
        pin_chk(1'h0, 1'h0);
        apb(1'h0, 12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        repeat (40) begin
            c = 8'($urandom);
            p = 8'($urandom);
            f = 8'($urandom);
            periph_flags <= f;
            apb(1'h1, irq_pkg::OFS_CTRL, {24'h0, c});
            apb(1'h1, irq_pkg::OFS_PERIPH_EN, {24'h0, p});
            pin_chk(exp_req(c, p, f), 1'h0);
            rd(irq_pkg::OFS_CTRL, {24'h0, c});
            rd(irq_pkg::OFS_PERIPH_EN, {24'h0, p});
        end
        periph_flags <= 8'h01;
        apb(1'h1, irq_pkg::OFS_PERIPH_EN, 32'h1);
        apb(1'h1, irq_pkg::OFS_CTRL, 32'h80);
        pin_chk(1'h0, 1'h0);
        apb(1'h1, irq_pkg::OFS_CTRL, 32'hC0);
        pin_chk(1'h1, 1'h0);
        periph_flags <= 8'h00;
        tmr_load <= 1'h1;
        @(posedge pclk);
        tmr_load <= 1'h0;
        apb(1'h1, irq_pkg::OFS_CTRL, 32'h0);
        tmr_run <= 1'h1;
        repeat (4) @(posedge pclk);
        tmr_run <= 1'h0;
        rd(irq_pkg::OFS_CTRL, 32'h4);
        apb(1'h1, irq_pkg::OFS_CTRL, 32'hA4);
        pin_chk(1'h1, 1'h0);
        apb(1'h1, irq_pkg::OFS_CTRL, 32'h24);
        pin_chk(1'h0, 1'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, irq_pkg::OFS_OPT, {31'h0, ~i[1]});
            apb(1'h1, irq_pkg::OFS_CTRL, 32'h0);
            ext_pin <= ~ext_pin;
            repeat (2) @(posedge pclk);
            rd(irq_pkg::OFS_CTRL, (i[0] == i[1]) ? 32'h2 : 32'h0);
        end
        repeat (8) begin
            c = 8'($urandom);
            f = 8'h01 << $urandom_range(7, 0);
            apb(1'h1, irq_pkg::OFS_PCHG, {24'h0, c});
            apb(1'h1, irq_pkg::OFS_CTRL, 32'h0);
            port_pins <= port_pins ^ f;
            repeat (2) @(posedge pclk);
            rd(irq_pkg::OFS_CTRL, {31'h0, (c & f) != 8'h00});
        end
        apb(1'h1, irq_pkg::OFS_MASK, 32'h4);
        pin_chk(1'h1, 1'h1);
        apb(1'h1, irq_pkg::OFS_STAT, 32'hF);
        pin_chk(1'h0, 1'h1);
        rd(irq_pkg::OFS_STAT, 32'h0);
        take_en <= 1'h1;
        apb(1'h1, irq_pkg::OFS_CTRL, 32'hA4);
        repeat (3) @(posedge pclk);
        take_en <= 1'h0;
        rd(irq_pkg::OFS_CTRL, 32'h24);
        chk({19'h0, vector_addr}, 32'h4);
        rd(irq_pkg::OFS_STAT, 32'h8);
        apb(1'h1, irq_pkg::OFS_MASK, 32'h8);
        pin_chk(1'h1, 1'h1);
        ret_cmd <= 1'h1;
        @(posedge pclk);
        ret_cmd <= 1'h0;
        rd(irq_pkg::OFS_CTRL, 32'hA4);
        // Low lane strobe off: the write must be dropped
        strb = 4'hE;
        apb(1'h1, irq_pkg::OFS_PERIPH_EN, 32'hFF);
        strb = 4'hF;
        rd(irq_pkg::OFS_PERIPH_EN, 32'h1);
        presetn <= 1'h0;
        @(posedge pclk);
        presetn <= 1'h1;
        rd(irq_pkg::OFS_CTRL, 32'h0);
        pin_chk(1'h0, 1'h0);
        pin_chk(1'h0, 1'h1);
        chk({19'h0, vector_addr}, 32'h0);
        tally_and_finish();
    end
endmodule
